// ===== logic/sdfs_sequencer.v
// Sector data field sequencer: sync bytes, interleaved elements and resync fields.
`timescale 1ns/100ps
`default_nettype none
`include "sdfs_consts.vh"

module sdfs_sequencer (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire        start_i,
    input  wire        fmt_512_i,
    input  wire [7:0]  in_data_i,
    input  wire        in_valid_i,
    output wire        in_ready_o,
    output wire [7:0]  out_data_o,
    output wire [2:0]  out_kind_o,
    output wire        out_valid_o,
    input  wire        out_ready_i,
    output wire        resync_alt_o,
    output wire [6:0]  out_row_o,
    output wire [4:0]  out_col_o,
    output wire        busy_o,
    output wire        done_o
);
    localparam ST_IDLE   = 2'd0;
    localparam ST_SYNC   = 2'd1;
    localparam ST_DATA   = 2'd2;
    localparam ST_RESYNC = 2'd3;

    reg  [1:0]  state_reg;
    reg  [11:0] pos_reg;
    reg  [5:0]  seg_reg;
    reg  [5:0]  rs_cnt_reg;
    reg  [1:0]  sync_cnt_reg;
    reg         fmt_reg;
    reg  [7:0]  buf_reg;
    reg         buf_full_reg;
    reg         in_ready_reg;
    reg  [7:0]  out_data_reg;
    reg  [2:0]  out_kind_reg;
    reg         out_valid_reg;
    reg         resync_alt_reg;
    reg  [6:0]  row_reg;
    reg  [4:0]  col_reg;
    reg         done_reg;
    reg         busy_reg;
    reg         busy_next;

    wire [2:0]  pos_kind;
    wire        pos_last;
    wire        rs_after;
    wire        can_load;
    wire        need_buf;
    wire        emit_elem;
    wire        take_in;
    wire        start_take;
    reg         buf_full_next;

    sdfs_pos_decode u_dec (
        .pos_i      (pos_reg),
        .fmt_512_i  (fmt_reg),
        .seg_i      (seg_reg),
        .rs_cnt_i   (rs_cnt_reg),
        .kind_o     (pos_kind),
        .last_o     (pos_last),
        .rs_after_o (rs_after)
    );

    // The output slot is free when empty or when the modulator takes the byte now.
    assign can_load  = !out_valid_reg || out_ready_i;
    assign need_buf  = (pos_kind != `SDFS_KIND_FILL);
    assign emit_elem = can_load && (state_reg == ST_DATA) && (!need_buf || buf_full_reg);
    assign take_in   = in_valid_i && in_ready_reg;
    // A start is refused while the last byte of the previous sector still waits.
    assign start_take = start_i && (state_reg == ST_IDLE) && !busy_reg;

    // Last column index of the selected format; the row steps down after it.
    function [4:0] col_last;
        input fmt;
        begin
            col_last = fmt ? (`SDFS_S_COLS - 5'd1) : (`SDFS_L_COLS - 5'd1);
        end
    endfunction

    // Busy covers the whole sector and a last byte still waiting at the output.
    always @* begin
        busy_next = 1'b0;
        if (state_reg != ST_IDLE) begin
            busy_next = 1'b1;
        end else if (start_take) begin
            busy_next = 1'b1;
        end else if (out_valid_reg && !out_ready_i) begin
            busy_next = 1'b1;
        end
    end

    // The one-byte staging register keeps in_ready_o a flop without dropping a byte.
    always @* begin
        buf_full_next = buf_full_reg;
        if (emit_elem && need_buf) begin
            buf_full_next = 1'b0;
        end
        if (take_in) begin
            buf_full_next = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg      <= ST_IDLE;
            pos_reg        <= 12'h001;
            seg_reg        <= 6'h00;
            rs_cnt_reg     <= 6'h00;
            sync_cnt_reg   <= 2'h0;
            fmt_reg        <= 1'b0;
            buf_reg        <= 8'h00;
            buf_full_reg   <= 1'b0;
            in_ready_reg   <= 1'b0;
            out_data_reg   <= 8'h00;
            out_kind_reg   <= 3'h0;
            out_valid_reg  <= 1'b0;
            resync_alt_reg <= 1'b0;
            row_reg        <= 7'h00;
            col_reg        <= 5'h00;
            done_reg       <= 1'b0;
            busy_reg       <= 1'b0;
        end else begin
            done_reg     <= 1'b0;
            busy_reg     <= busy_next;
            buf_full_reg <= buf_full_next;
            in_ready_reg <= !buf_full_next;
            if (take_in) begin
                buf_reg <= in_data_i;
            end
            if (out_ready_i) begin
                out_valid_reg <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    // Holding the start off keeps the format latch still under a pending byte.
                    if (start_take) begin
                        // Format is latched here and held for the whole sector.
                        fmt_reg      <= fmt_512_i;
                        pos_reg      <= 12'h001;
                        seg_reg      <= 6'h00;
                        rs_cnt_reg   <= 6'h00;
                        sync_cnt_reg <= 2'h0;
                        row_reg      <= fmt_512_i ? `SDFS_S_ROWS : `SDFS_L_ROWS;
                        col_reg      <= 5'h00;
                        state_reg    <= ST_SYNC;
                    end
                end
                ST_SYNC: begin
                    if (can_load) begin
                        out_data_reg  <= `SDFS_SYNC_VALUE;
                        out_kind_reg  <= `SDFS_KIND_SYNC;
                        out_valid_reg <= 1'b1;
                        sync_cnt_reg  <= sync_cnt_reg + 2'h1;
                        if (sync_cnt_reg == `SDFS_SYNC_COUNT) begin
                            state_reg <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (emit_elem) begin
                        out_kind_reg  <= pos_kind;
                        out_valid_reg <= 1'b1;
                        if (pos_kind == `SDFS_KIND_FILL) begin
                            out_data_reg <= `SDFS_FILL_VALUE;
                        end else if (pos_kind == `SDFS_KIND_ECC) begin
                            out_data_reg <= ~buf_reg;
                        end else begin
                            out_data_reg <= buf_reg;
                        end
                        // Row counts down through zero into the ECC lines, wrapping to -1.
                        if (col_reg == col_last(fmt_reg)) begin
                            col_reg <= 5'h00;
                            row_reg <= row_reg - 7'd1;
                        end else begin
                            col_reg <= col_reg + 5'd1;
                        end
                        pos_reg <= pos_reg + 12'h001;
                        seg_reg <= seg_reg + 6'h01;
                        if (pos_last) begin
                            done_reg  <= 1'b1;
                            state_reg <= ST_IDLE;
                        end else if (rs_after) begin
                            state_reg <= ST_RESYNC;
                        end
                    end
                end
                default: begin
                    if (can_load) begin
                        // The resync number rides in the data byte; the position is not advanced.
                        out_data_reg   <= {2'b00, rs_cnt_reg + 6'h01};
                        out_kind_reg   <= `SDFS_KIND_RESYNC;
                        out_valid_reg  <= 1'b1;
                        resync_alt_reg <= rs_cnt_reg[0];
                        rs_cnt_reg     <= rs_cnt_reg + 6'h01;
                        seg_reg        <= 6'h00;
                        state_reg      <= ST_DATA;
                    end
                end
            endcase
        end
    end

    assign in_ready_o   = in_ready_reg;
    assign out_data_o   = out_data_reg;
    assign out_kind_o   = out_kind_reg;
    assign out_valid_o  = out_valid_reg;
    assign resync_alt_o = resync_alt_reg;
    assign out_row_o    = row_reg;
    assign out_col_o    = col_reg;
    assign busy_o       = busy_reg;
    assign done_o       = done_reg;
endmodule
`default_nettype wire

// ===== logic/sdfs_consts.vh
// Constants for the sector data field sequencer.
`ifndef SDFS_CONSTS_VH
`define SDFS_CONSTS_VH

// Element positions n of the recorded sequence, 2048-byte sectors.
`define SDFS_L_FILL_FIRST   12'd2049
`define SDFS_L_CRC_FIRST    12'd2057
`define SDFS_L_ECC_FIRST    12'd2061
`define SDFS_L_LAST         12'd2380
`define SDFS_L_RS_PERIOD    6'd60
`define SDFS_L_RS_COUNT     6'd39
`define SDFS_L_COLS         5'd20
`define SDFS_L_ROWS         7'd102

// Element positions n of the recorded sequence, 512-byte sectors.
`define SDFS_S_FILL_FIRST   12'd513
`define SDFS_S_CRC_FIRST    12'd517
`define SDFS_S_ECC_FIRST    12'd521
`define SDFS_S_LAST         12'd600
`define SDFS_S_RS_PERIOD    6'd20
`define SDFS_S_RS_COUNT     6'd29
`define SDFS_S_COLS         5'd5
`define SDFS_S_ROWS         7'd103

`define SDFS_ECC_ROWS       7'd16
`define SDFS_SYNC_COUNT     2'd3
`define SDFS_SYNC_VALUE     8'h00
`define SDFS_FILL_VALUE     8'hff

// Kind codes of the outgoing element.
`define SDFS_KIND_SYNC      3'h0
`define SDFS_KIND_USER      3'h1
`define SDFS_KIND_FILL      3'h2
`define SDFS_KIND_CRC       3'h3
`define SDFS_KIND_ECC       3'h4
`define SDFS_KIND_RESYNC    3'h5

`endif

// ===== logic/sdfs_pos_decode.v
// Classifies a sequence position n of the data field for the selected sector size.
`timescale 1ns/100ps
`default_nettype none
`include "sdfs_consts.vh"

module sdfs_pos_decode (
    input  wire [11:0] pos_i,
    input  wire        fmt_512_i,
    input  wire [5:0]  seg_i,
    input  wire [5:0]  rs_cnt_i,
    output reg  [2:0]  kind_o,
    output reg         last_o,
    output reg         rs_after_o
);
    reg [11:0] fill_first;
    reg [11:0] crc_first;
    reg [11:0] ecc_first;
    reg [11:0] last_pos;
    reg [5:0]  period;
    reg [5:0]  rs_max;

    always @* begin
        fill_first = fmt_512_i ? `SDFS_S_FILL_FIRST : `SDFS_L_FILL_FIRST;
        crc_first  = fmt_512_i ? `SDFS_S_CRC_FIRST  : `SDFS_L_CRC_FIRST;
        ecc_first  = fmt_512_i ? `SDFS_S_ECC_FIRST  : `SDFS_L_ECC_FIRST;
        last_pos   = fmt_512_i ? `SDFS_S_LAST       : `SDFS_L_LAST;
        period     = fmt_512_i ? `SDFS_S_RS_PERIOD  : `SDFS_L_RS_PERIOD;
        rs_max     = fmt_512_i ? `SDFS_S_RS_COUNT   : `SDFS_L_RS_COUNT;
        if (pos_i >= ecc_first) begin
            kind_o = `SDFS_KIND_ECC;
        end else if (pos_i >= crc_first) begin
            kind_o = `SDFS_KIND_CRC;
        end else if (pos_i >= fill_first) begin
            kind_o = `SDFS_KIND_FILL;
        end else begin
            kind_o = `SDFS_KIND_USER;
        end
        last_o     = (pos_i == last_pos);
        // The segment count is taken before it steps, so the element that
        // completes a segment is the one seen at the count below the period.
        rs_after_o = (seg_i == period - 6'd1) && (rs_cnt_i < rs_max);
    end
endmodule
`default_nettype wire

// ===== tb/sdfs_seq_sva.sv
// Port assertions for the sector data field sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "sdfs_consts.vh"
module sdfs_seq_sva (
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic       start_i,
    input wire logic [7:0] out_data_o,
    input wire logic [2:0] out_kind_o,
    input wire logic       out_valid_o,
    input wire logic       out_ready_i,
    input wire logic       resync_alt_o,
    input wire logic       busy_o,
    input wire logic       done_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence rs_out;
        out_valid_o && out_kind_o == `SDFS_KIND_RESYNC;
    endsequence
    sequence rs_take;
        rs_out ##0 out_ready_i;
    endsequence
    out_hold_a: assert property (
        out_valid_o && !out_ready_i |=> $stable({out_valid_o, out_kind_o, out_data_o}))
        else $error("stalled output moved");
    fill_ones_a: assert property (
        out_valid_o && out_kind_o == `SDFS_KIND_FILL |-> out_data_o == `SDFS_FILL_VALUE)
        else $error("filler not all ones");
    start_sync_a: assert property (
        start_i && !busy_o |=> ##1 out_valid_o && out_kind_o == `SDFS_KIND_SYNC)
        else $error("no sync after start");
    rs_number_a: assert property (
        rs_out |-> out_data_o inside {[8'h01:8'h27]})
        else $error("resync number out of range");
    rs_pattern_a: assert property (
        rs_out |-> resync_alt_o == !out_data_o[0])
        else $error("resync variant wrong");
    rs_single_a: assert property (
        rs_take |=> not rs_out)
        else $error("two resyncs in a row");
    done_pulse_a: assert property (
        done_o |=> !done_o)
        else $error("done longer than one cycle");
    idle_quiet_a: assert property (
        !busy_o |-> !out_valid_o)
        else $error("output while idle");
endmodule
bind sdfs_sequencer sdfs_seq_sva i_sdfs_seq_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .start_i(start_i), .out_data_o(out_data_o), .out_kind_o(out_kind_o),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .resync_alt_o(resync_alt_o),
    .busy_o(busy_o), .done_o(done_o));
`default_nettype wire

// ===== tb/sdfs_mod_model.sv
// Channel bit modulator model that takes bytes, stalling on request.
`timescale 1ns/100ps
`default_nettype none
module sdfs_mod_model (
    input  wire logic clk_i,
    input  wire logic slow_i,
    output var  logic ready_o
);
    logic [1:0] ph_reg = 2'h0;
    initial ready_o = 1'b0;
    // Bytes are taken in arrival order; one stall in four exercises the hold path.
    always @(posedge clk_i) begin
        ph_reg <= ph_reg + 2'h1;
        ready_o <= !(slow_i && ph_reg == 2'h3);
    end
endmodule
`default_nettype wire

// ===== tb/sdfs_sequencer_tb.sv
// Self-checking bench for the sector data field sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "sdfs_consts.vh"
module sdfs_sequencer_tb;
    logic       clk_i = 1'b0, sys_rst_i = 1'b1, start_i = 1'b0, fmt_512_i = 1'b0;
    logic       in_valid_i = 1'b0, slow = 1'b0, src_on = 1'b0;
    logic [7:0] in_data_i = 8'h00;
    wire        in_ready_o, out_valid_o, out_ready_i, resync_alt_o, busy_o, done_o;
    wire  [7:0] out_data_o;
    wire  [2:0] out_kind_o;
    wire  [6:0] out_row_o;
    wire  [4:0] out_col_o;
    int         num_errors = 0, checked = 0, src_idx = 0, src_tot = 0, dones = 0;
    int         flen = 0, fpad = 0;
    initial forever #4 clk_i = ~clk_i;
    sdfs_sequencer i_sdfs_sequencer (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
        .fmt_512_i(fmt_512_i), .in_data_i(in_data_i), .in_valid_i(in_valid_i),
        .in_ready_o(in_ready_o), .out_data_o(out_data_o), .out_kind_o(out_kind_o),
        .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .resync_alt_o(resync_alt_o),
        .out_row_o(out_row_o), .out_col_o(out_col_o), .busy_o(busy_o), .done_o(done_o));
    sdfs_mod_model i_sdfs_mod_model (.clk_i(clk_i), .slow_i(slow), .ready_o(out_ready_i));
    // Upstream bytes carry their position; filler is skipped because the block makes it.
    always @(posedge clk_i) begin
        if (in_valid_i && in_ready_o) src_idx = src_idx + 1;
        in_valid_i <= src_on && src_idx < src_tot;
        in_data_i <= 8'(src_idx + ((src_idx >= flen) ? fpad : 1));
        if (done_o === 1'b1) dones = dones + 1;
    end
    task automatic chk(input string w, input logic [10:0] x, input logic [10:0] g);
        checked++;
        if (g !== x) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", w, x, g);
        end
    endtask
    task automatic results;
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic logic [10:0] elem(input logic f, input int n);
        if (n > (f ? 520 : 2060)) return {`SDFS_KIND_ECC, ~8'(n)};
        if (n > (f ? 516 : 2056)) return {`SDFS_KIND_CRC, 8'(n)};
        if (n > (f ? 512 : 2048)) return {`SDFS_KIND_FILL, 8'hff};
        return {`SDFS_KIND_USER, 8'(n)};
    endfunction
    task automatic run_sector(input logic f, input logic s);
        int p = f ? 20 : 60;
        int nrs = f ? 29 : 39;
        int tot = f ? 633 : 2423;
        int c = f ? 5 : 20;
        int r0 = f ? 103 : 102;
        int sc = 0, n = 0, k = 0, outs = 0, cyc = 0;
        logic rs = 1'b0;
        logic [10:0] e;
        fmt_512_i <= f;
        slow <= s;
        flen = f ? 512 : 2048;
        fpad = f ? 5 : 9;
        src_tot = f ? 596 : 2372;
        src_idx = 0;
        dones = 0;
        src_on <= 1'b1;
        start_i <= 1'b1;
        while (outs < tot && cyc < 9000) begin
            @(posedge clk_i);
            cyc++;
            // A second start while busy must not restart the sector.
            start_i <= (cyc == 40);
            if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
                outs++;
                if (sc < 4) begin
                    sc++;
                    e = {`SDFS_KIND_SYNC, `SDFS_SYNC_VALUE};
                end else if (rs) begin
                    rs = 1'b0;
                    e = {`SDFS_KIND_RESYNC, 8'(k)};
                    chk("alt", {10'h000, ~k[0]}, {10'h000, resync_alt_o});
                end else begin
                    n++;
                    e = elem(f, n);
                    chk("col", 11'(n % c), {6'h00, out_col_o});
                    chk("row", {4'h0, 7'(r0 - n / c)}, {4'h0, out_row_o});
                    k = n / p;
                    rs = n % p == 0 && k <= nrs;
                end
                chk("elem", e, {out_kind_o, out_data_o});
            end
        end
        if (cyc >= 9000) begin
            chk("outs", 11'(tot), 11'(outs));
            results;
        end
        repeat (4) @(posedge clk_i);
        chk("done", 11'h001, 11'(dones));
        chk("busy", 11'h000, {10'h000, busy_o});
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        run_sector(1'b0, 1'b1);
        run_sector(1'b1, 1'b0);
        results;
    end
endmodule
`default_nettype wire
